// *** sqr_consts.svh ***
// Register map, field positions, reset values and fixed codes of the sample queue.
`ifndef SQR_CONSTS_SVH
`define SQR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SQR_A_CONFIG 8'h1A
`define SQR_A_CAP_EN 8'h23
`define SQR_A_INT_STATUS 8'h3A
`define SQR_A_LEVEL_HIGH 8'h72
`define SQR_A_LEVEL_LOW 8'h73
`define SQR_A_DATA_PORT 8'h74
`define SQR_A_IDENTITY 8'h75
`define SQR_A_XOFS_HIGH 8'h77
`define SQR_A_XOFS_LOW 8'h78
`define SQR_A_YOFS_HIGH 8'h7A
`define SQR_A_YOFS_LOW 8'h7B
`define SQR_A_ZOFS_HIGH 8'h7D
`define SQR_A_ZOFS_LOW 8'h7E

// ----------------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------------
`define SQR_CFG_KEEP_OLDEST_BIT 6
`define SQR_OFLOW_BIT 4
`define SQR_EN_TEMP_BIT 7
`define SQR_EN_XG_BIT 6
`define SQR_EN_YG_BIT 5
`define SQR_EN_ZG_BIT 4
`define SQR_EN_ACCEL_BIT 3
`define SQR_IDX_LAST 4'hD
`define SQR_IDX_TEMP 4'h6
`define SQR_IDX_XG 4'h8
`define SQR_IDX_YG 4'hA
`define SQR_IDX_ZG 4'hC
`define SQR_EMPTY_MARK 8'hFF
`define SQR_MARK_SUBST 8'hFE
`define SQR_RESET_BYTE 8'h00
`define SQR_I2C_ADDR0 7'h68
`define SQR_I2C_ADDR1 7'h69
`define SQR_ID_CODE 8'h5C
`define SQR_BITS_PER_BYTE 4'h8
`define SQR_QUEUE_WIDTH 8
`define SQR_QUEUE_DEPTH 16
`define SQR_QUEUE_AW 4

`endif

// *** sqr_pkg.sv ***
// Types shared by the sample queue register block.
package sqr_pkg;

	// Sensor data bytes, element 0 is register 59, element 13 is register 72.
	typedef struct packed {
		logic [13:0][7:0] b;
	} sqr_sample_s;

	// One byte offered to the queue.
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sqr_push_s;

	typedef enum logic [8:0] {
		I_IDLE = 9'h001,
		I_ADDR = 9'h002,
		I_AACK = 9'h004,
		I_PTR = 9'h008,
		I_PACK = 9'h010,
		I_WDAT = 9'h020,
		I_WACK = 9'h040,
		I_RDAT = 9'h080,
		I_RACK = 9'h100
	} sqr_bus_state_e;

	typedef enum logic [1:0] {
		C_IDLE = 2'h1,
		C_RUN = 2'h2
	} sqr_cap_state_e;

endpackage

// *** sqr_fifo.sv ***
// Byte queue with valid/ready on both sides and a registered read port.
`timescale 1ns/1ps
`default_nettype none
module sqr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data,
	output logic [AW:0] level
);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] rptr_r;
	logic [AW:0] cnt_r;
	logic [WIDTH-1:0] rdata_r;
	wire logic full = (cnt_r == (AW+1)'(DEPTH));
	wire logic do_rd = rd_valid && rd_ready;
	// A pop in the same cycle frees a slot, so a full queue may still take.
	wire logic do_wr = wr_valid && wr_ready;

	assign rd_valid = (cnt_r != '0);
	assign wr_ready = !full || do_rd;
	assign rd_data = rdata_r;
	assign level = cnt_r;

	// ----------------------------------------------------------------------
	// Storage; the popped word lands in a register one cycle later.
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wptr_r] <= wr_data;
		end
		if (do_rd) begin
			rdata_r <= mem[rptr_r];
		end
	end

	// Pointers and fill count.
	always_ff @(posedge clk) begin
		if (rst) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (do_wr) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (do_rd) begin
				rptr_r <= rptr_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule
`default_nettype wire

// *** sqr_core.sv ***
// Two-wire register target with the sample queue, level snapshot and trims.
// How it works
// - Level is 13 bits; high byte holds bits 12..8 in 4..0, rest zero.
// - Reading the high level byte snapshots both level bytes together.
// - Data port read pops next byte; data port write pushes the byte.
// - Each capture pushes enabled sensor bytes in ascending register order.
// - With all enables set, registers 59 to 72 go in per sample.
// - A sensor byte is queued only if its enable bit was one at the sample tick.
// - Overflow sets the overflow flag in the interrupt status register.
// - Mode bit clear drops oldest bytes on overflow; set keeps oldest.
// - Reading an empty queue returns 0xFF until fresh data arrives.
// - Queued bytes never equal 0xFF, so 0xFF always means empty.
// - Identity register is read-only and returns a fixed eight-bit code.
// - Bus address is 0x68 or 0x69 from the select pin, not the identity.
// - Each axis trim is 15 bits: high byte 14..7, low byte 7..1.
// - Trims weigh 0.98 mg per step over 16 g in every range.
`timescale 1ns/1ps
`default_nettype none
`include "sqr_consts.svh"
module sqr_core import sqr_pkg::*; #(
	parameter logic [7:0] ID_CODE = `SQR_ID_CODE // Arbitrary value.
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic address_select_pin,
	input wire logic sample_tick,
	input wire sqr_sample_s sample,
	output logic [14:0] accel_x_trim,
	output logic [14:0] accel_y_trim,
	output logic [14:0] accel_z_trim,
	output logic queue_overflow_flag
);
	// ----------------------------------------------------------------------
	// Pin synchronisers and edge finders
	// ----------------------------------------------------------------------
	logic scl_s1_r, scl_s2_r, scl_s3_r;
	logic sda_s1_r, sda_s2_r, sda_s3_r;
	logic sel_s1_r, sel_s2_r;

	// Only the second stage and its delayed copy feed any logic.
	always_ff @(posedge mclk) begin
		scl_s1_r <= scl;
		scl_s2_r <= scl_s1_r;
		scl_s3_r <= scl_s2_r;
		sda_s1_r <= sda_in;
		sda_s2_r <= sda_s1_r;
		sda_s3_r <= sda_s2_r;
		sel_s1_r <= address_select_pin;
		sel_s2_r <= sel_s1_r;
	end

	wire logic scl_rise = scl_s2_r && !scl_s3_r;
	wire logic scl_fall = !scl_s2_r && scl_s3_r;
	wire logic bus_start = scl_s2_r && scl_s3_r && !sda_s2_r && sda_s3_r;
	wire logic bus_stop = scl_s2_r && scl_s3_r && sda_s2_r && !sda_s3_r;
	wire logic [6:0] my_addr = sel_s2_r ? `SQR_I2C_ADDR1 : `SQR_I2C_ADDR0;

	// ----------------------------------------------------------------------
	// Two-wire target state
	// ----------------------------------------------------------------------
	sqr_bus_state_e st_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [7:0] ptr_r;
	logic rw_r;
	logic fetch_r;
	logic load_r;
	logic popped_r;
	logic wr_pulse_r;
	logic [7:0] wr_byte_r;
	wire logic [7:0] rd_byte;

	wire logic byte_done = (bit_cnt_r == `SQR_BITS_PER_BYTE);
	// A read byte is fetched on the rising edge of the acknowledge clock.
	wire logic fetch_now = scl_rise &&
		((st_r == I_AACK && rw_r) || (st_r == I_RACK && !sda_s2_r));

	// Receive shifter and state; a start or stop overrides any phase.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_r <= I_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= `SQR_RESET_BYTE;
			rw_r <= 1'b0;
		end else if (bus_start) begin
			st_r <= I_ADDR;
			bit_cnt_r <= 4'h0;
		end else if (bus_stop) begin
			st_r <= I_IDLE;
		end else if (scl_rise) begin
			shift_r <= {shift_r[6:0], sda_s2_r};
			bit_cnt_r <= bit_cnt_r + 4'h1;
			if (st_r == I_RACK && sda_s2_r) begin
				st_r <= I_IDLE; // Host refused more data.
			end
		end else if (scl_fall) begin
			unique case (st_r)
				I_IDLE: st_r <= I_IDLE;
				I_ADDR: if (byte_done) begin
					st_r <= (shift_r[7:1] == my_addr) ? I_AACK : I_IDLE;
					rw_r <= shift_r[0];
				end
				I_AACK: begin
					st_r <= rw_r ? I_RDAT : I_PTR;
					bit_cnt_r <= 4'h0;
				end
				I_PTR: if (byte_done) st_r <= I_PACK;
				I_PACK, I_WACK: begin
					st_r <= I_WDAT;
					bit_cnt_r <= 4'h0;
				end
				I_WDAT: if (byte_done) st_r <= I_WACK;
				I_RDAT: if (byte_done) st_r <= I_RACK;
				I_RACK: begin
					st_r <= I_RDAT;
					bit_cnt_r <= 4'h0;
				end
			endcase
		end
	end

	// Open-drain drive: pull low for an acknowledge or a zero data bit.
	always_ff @(posedge mclk) begin
		if (sys_rst || bus_start || bus_stop) begin
			sda_oe <= 1'b0;
		end else if (scl_fall) begin
			if ((st_r == I_ADDR && byte_done && shift_r[7:1] == my_addr) ||
				((st_r == I_PTR || st_r == I_WDAT) && byte_done)) begin
				sda_oe <= 1'b1;
			end else if (st_r == I_AACK && rw_r || st_r == I_RACK) begin
				sda_oe <= !tx_r[7];
			end else if (st_r == I_RDAT && !byte_done) begin
				sda_oe <= !tx_r[6];
			end else begin
				sda_oe <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		sda_out <= 1'b0;
	end

	// Fetch pipeline: cycle one pops or snapshots, cycle two loads tx.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fetch_r <= 1'b0;
			load_r <= 1'b0;
		end else begin
			fetch_r <= fetch_now;
			load_r <= fetch_r;
		end
	end

	// Transmit shifter: loaded after a fetch, shifted while sending.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tx_r <= `SQR_RESET_BYTE;
		end else if (load_r) begin
			tx_r <= rd_byte;
		end else if (scl_fall && st_r == I_RDAT && !byte_done) begin
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end

	// Host write strobe, raised when a data byte completes.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_pulse_r <= 1'b0;
			wr_byte_r <= `SQR_RESET_BYTE;
		end else begin
			wr_pulse_r <= scl_fall && st_r == I_WDAT && byte_done;
			wr_byte_r <= shift_r;
		end
	end

	// Pointer steps after each access but stays on the data port.
	wire logic ptr_step = (load_r || wr_pulse_r) && ptr_r != `SQR_A_DATA_PORT;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ptr_r <= `SQR_RESET_BYTE;
		end else if (scl_fall && st_r == I_PTR && byte_done) begin
			ptr_r <= shift_r;
		end else if (ptr_step) begin
			ptr_r <= ptr_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------------
	// Control and trim registers
	// ----------------------------------------------------------------------
	logic [7:0] cfg_r;
	logic [7:0] cap_en_r;
	logic [7:0] xh_r, xl_r, yh_r, yl_r, zh_r, zl_r;
	logic [12:0] snap_r;

	wire logic wr_hit_data = wr_pulse_r && ptr_r == `SQR_A_DATA_PORT;
	wire logic keep_oldest = cfg_r[`SQR_CFG_KEEP_OLDEST_BIT];

	// Writes to reserved offsets and read-only registers are ignored.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cfg_r <= `SQR_RESET_BYTE;
			cap_en_r <= `SQR_RESET_BYTE;
			{xh_r, xl_r, yh_r, yl_r, zh_r, zl_r} <= '0;
		end else if (wr_pulse_r) begin
			if (ptr_r == `SQR_A_CONFIG) cfg_r <= wr_byte_r;
			if (ptr_r == `SQR_A_CAP_EN) cap_en_r <= wr_byte_r;
			if (ptr_r == `SQR_A_XOFS_HIGH) xh_r <= wr_byte_r;
			if (ptr_r == `SQR_A_XOFS_LOW) xl_r <= wr_byte_r;
			if (ptr_r == `SQR_A_YOFS_HIGH) yh_r <= wr_byte_r;
			if (ptr_r == `SQR_A_YOFS_LOW) yl_r <= wr_byte_r;
			if (ptr_r == `SQR_A_ZOFS_HIGH) zh_r <= wr_byte_r;
			if (ptr_r == `SQR_A_ZOFS_LOW) zl_r <= wr_byte_r;
		end
	end

	// Trims leave in the fixed 16 g, 0.98 mg scale whatever the range.
	always_ff @(posedge mclk) begin
		accel_x_trim <= {xh_r, xl_r[7:1]};
		accel_y_trim <= {yh_r, yl_r[7:1]};
		accel_z_trim <= {zh_r, zl_r[7:1]};
	end

	// ----------------------------------------------------------------------
	// Queue, capture sequencer and overflow
	// ----------------------------------------------------------------------
	logic q_wr_ready, q_rd_valid;
	logic [7:0] q_rd_data;
	logic [4:0] q_level;
	sqr_cap_state_e cap_st_r;
	sqr_sample_s cap_snap_r;
	logic [7:0] cap_mask_r;
	logic [3:0] cap_idx_r;
	sqr_push_s push;

	// Map a sensor byte index to its capture enable bit.
	function automatic logic cap_enabled(input logic [3:0] idx,
		input logic [7:0] en);
		if (idx < `SQR_IDX_TEMP) return en[`SQR_EN_ACCEL_BIT];
		else if (idx < `SQR_IDX_XG) return en[`SQR_EN_TEMP_BIT];
		else if (idx < `SQR_IDX_YG) return en[`SQR_EN_XG_BIT];
		else if (idx < `SQR_IDX_ZG) return en[`SQR_EN_YG_BIT];
		else return en[`SQR_EN_ZG_BIT];
	endfunction

	// The host write owns the push slot; capture waits for it to pass.
	wire logic cap_step = cap_st_r == C_RUN && !wr_hit_data;
	wire logic cap_push = cap_step && cap_enabled(cap_idx_r, cap_mask_r);
	wire logic [7:0] raw_byte = wr_hit_data ? wr_byte_r :
		cap_snap_r.b[cap_idx_r];
	wire logic [7:0] safe_byte = (raw_byte == `SQR_EMPTY_MARK) ?
		`SQR_MARK_SUBST : raw_byte;
	assign push = {wr_hit_data || cap_push, safe_byte};

	// Sample tick latches the bytes, then one byte per cycle, low first.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cap_st_r <= C_IDLE;
			cap_idx_r <= 4'h0;
			cap_mask_r <= `SQR_RESET_BYTE;
			cap_snap_r <= '0;
		end else unique case (cap_st_r)
			C_IDLE: if (sample_tick) begin
				cap_st_r <= C_RUN;
				cap_idx_r <= 4'h0;
				cap_snap_r <= sample;
				cap_mask_r <= cap_en_r;
			end
			C_RUN: if (cap_step) begin
				cap_idx_r <= cap_idx_r + 4'h1;
				if (cap_idx_r == `SQR_IDX_LAST) cap_st_r <= C_IDLE;
			end
		endcase
	end

	// Host pops only when a byte exists, so an empty read leaves the level.
	wire logic host_pop = fetch_r && ptr_r == `SQR_A_DATA_PORT && q_rd_valid;
	wire logic q_full = !q_wr_ready && !host_pop;
	wire logic overflow = push.valid && (q_level == 5'(`SQR_QUEUE_DEPTH)) &&
		!host_pop;
	wire logic drop_oldest = overflow && !keep_oldest;

	// With the mode bit set a full queue refuses the new byte.
	sqr_fifo #(
		.WIDTH(`SQR_QUEUE_WIDTH),
		.DEPTH(`SQR_QUEUE_DEPTH),
		.AW(`SQR_QUEUE_AW)
	) u_queue (
		.clk(mclk),
		.rst(sys_rst),
		.wr_valid(push.valid),
		.wr_ready(q_wr_ready),
		.wr_data(push.data),
		.rd_valid(q_rd_valid),
		.rd_ready(host_pop || drop_oldest),
		.rd_data(q_rd_data),
		.level(q_level)
	);

	// Sticky overflow flag, cleared by reading status; a new overflow wins.
	// The clear waits for the load cycle so the host still sees the set bit.
	wire logic status_read = load_r && ptr_r == `SQR_A_INT_STATUS;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			queue_overflow_flag <= 1'b0;
		end else if (overflow || (push.valid && q_full)) begin
			queue_overflow_flag <= 1'b1;
		end else if (status_read) begin
			queue_overflow_flag <= 1'b0;
		end
	end

	// Level snapshot and whether the last fetch got a real byte.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			snap_r <= '0;
			popped_r <= 1'b0;
		end else if (fetch_r) begin
			if (ptr_r == `SQR_A_LEVEL_HIGH) snap_r <= 13'(q_level);
			popped_r <= host_pop;
		end
	end

	// ----------------------------------------------------------------------
	// Read selection
	// ----------------------------------------------------------------------
	wire logic [7:0] status_byte = 8'(queue_overflow_flag) <<
		`SQR_OFLOW_BIT;
	wire logic [7:0] data_byte = popped_r ? q_rd_data : `SQR_EMPTY_MARK;
	assign rd_byte =
		(ptr_r == `SQR_A_CONFIG) ? cfg_r :
		(ptr_r == `SQR_A_CAP_EN) ? cap_en_r :
		(ptr_r == `SQR_A_INT_STATUS) ? status_byte :
		(ptr_r == `SQR_A_LEVEL_HIGH) ? {3'h0, snap_r[12:8]} :
		(ptr_r == `SQR_A_LEVEL_LOW) ? snap_r[7:0] :
		(ptr_r == `SQR_A_DATA_PORT) ? data_byte :
		(ptr_r == `SQR_A_IDENTITY) ? ID_CODE :
		(ptr_r == `SQR_A_XOFS_HIGH) ? xh_r :
		(ptr_r == `SQR_A_XOFS_LOW) ? {xl_r[7:1], 1'b0} :
		(ptr_r == `SQR_A_YOFS_HIGH) ? yh_r :
		(ptr_r == `SQR_A_YOFS_LOW) ? {yl_r[7:1], 1'b0} :
		(ptr_r == `SQR_A_ZOFS_HIGH) ? zh_r :
		(ptr_r == `SQR_A_ZOFS_LOW) ? {zl_r[7:1], 1'b0} :
		`SQR_RESET_BYTE;
endmodule
`default_nettype wire

// *** sqr_core_properties.sv ***
// Port-level checks on the sample queue register block.
`timescale 1ns/1ps
`default_nettype none
module sqr_core_properties import sqr_pkg::*; (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic address_select_pin,
	input wire logic sample_tick,
	input wire sqr_sample_s sample,
	input wire logic [14:0] accel_x_trim,
	input wire logic [14:0] accel_y_trim,
	input wire logic [14:0] accel_z_trim,
	input wire logic queue_overflow_flag
);
	// ------------------------------------------------------------
	// Activity ages
	// ------------------------------------------------------------
	// Cycles since bus or capture activity; saturating so they never wrap.
	logic scl_q_r;
	logic [5:0] bus_age_r;
	logic [5:0] tick_age_r;
	wire logic [5:0] bus_age_nxt = (scl != scl_q_r) ? 6'h00 :
		bus_age_r + {5'h00, ~&bus_age_r};
	wire logic [5:0] tick_age_nxt = sample_tick ? 6'h00 :
		tick_age_r + {5'h00, ~&tick_age_r};
	// Age registers start saturated, as if nothing had happened.
	always_ff @(posedge mclk) begin
		scl_q_r <= scl;
		bus_age_r <= sys_rst ? 6'h3F : bus_age_nxt;
		tick_age_r <= sys_rst ? 6'h3F : tick_age_nxt;
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_reset_outputs_clear: assert property ($fell(sys_rst) |->
		!sda_oe && !queue_overflow_flag)
		else $error("outputs not clear after reset");
	a_reset_trims_zero: assert property ($fell(sys_rst) |->
		{accel_x_trim, accel_y_trim, accel_z_trim} == 45'h0)
		else $error("trims not zero after reset");
	a_sda_out_low: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	a_oe_after_fall: assert property ($changed(sda_oe) |->
		!$past(scl) && !$past(scl, 2))
		else $error("data pin changed outside clock low phase");
	a_oe_stands_high: assert property ($rose(scl) |->
		##2 $stable(sda_oe) [*3])
		else $error("data pin moved while clock high");
	a_oe_bus_only: assert property (sda_oe |-> bus_age_r < 6'h0C)
		else $error("data pin pulled with no bus activity");
	a_flag_has_cause: assert property ($rose(queue_overflow_flag) |->
		tick_age_r < 6'h14 || bus_age_r < 6'h0C)
		else $error("overflow flag rose without a push");
	a_trim_has_cause: assert property ($changed({accel_x_trim,
		accel_y_trim, accel_z_trim}) |-> bus_age_r < 6'h0C)
		else $error("trim changed without a bus write");
endmodule
bind sqr_core sqr_core_properties u_props (.mclk, .sys_rst, .scl, .sda_in,
	.sda_out, .sda_oe, .address_select_pin, .sample_tick, .sample,
	.accel_x_trim, .accel_y_trim, .accel_z_trim, .queue_overflow_flag);
`default_nettype wire

// *** sqr_host_model.sv ***
// Two-wire bus host that drives frames into the register block.
`timescale 1ns/1ps
`default_nettype none
module sqr_host_model (
	input wire logic mclk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	// Both lines released between frames; the pull-ups hold them high.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// A quarter of the 160 ns bus period; lines move just after an edge.
	task automatic q;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	// Start: the extra wait lets a late acknowledge release first.
	task automatic start;
		sda_low = 1'b0;
		q;
		q;
		scl = 1'b1;
		q;
		sda_low = 1'b1;
		q;
		scl = 1'b0;
		q;
	endtask
	// Stop: the data line rises while the clock is high.
	task automatic stop;
		sda_low = 1'b1;
		q;
		scl = 1'b1;
		q;
		sda_low = 1'b0;
		q;
	endtask
	// One clock: data set in the low half, sampled mid high half.
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		q;
		scl = 1'b1;
		q;
		r = sda_line;
		q;
		scl = 1'b0;
		q;
	endtask
	// Eight bits most significant first, then the acknowledge clock.
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] r, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], b);
			r[i] = b;
		end
		bit_io(ack_in, ack);
	endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the sample queue register block.
`timescale 1ns/1ps
`default_nettype none
`include "sqr_consts.svh"
module tb import sqr_pkg::*; ;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [7:0] TB_ID = 8'h3C; // Arbitrary identity value.
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic address_select_pin = 1'b0;
	logic sample_tick = 1'b0;
	sqr_sample_s sample = '0;
	logic scl;
	logic sda_low;
	logic sda_out;
	logic sda_oe;
	logic [14:0] accel_x_trim;
	logic [14:0] accel_y_trim;
	logic [14:0] accel_z_trim;
	logic queue_overflow_flag;
	logic [6:0] dev = `SQR_I2C_ADDR0;
	logic nak_seen;
	int err_count = 0;
	int check_count = 0;
	// Open-drain line with pull-up: low while either party pulls it.
	wire logic sda_line = !(sda_oe === 1'b1 || sda_low);
	always #10 mclk = ~mclk;
	sqr_core #(.ID_CODE(TB_ID)) DUT (.mclk, .sys_rst, .scl,
		.sda_in(sda_line), .sda_out, .sda_oe, .address_select_pin,
		.sample_tick, .sample, .accel_x_trim, .accel_y_trim,
		.accel_z_trim, .queue_overflow_flag);
	sqr_host_model host (.mclk, .sda_line, .scl, .sda_low);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %0t %s: %h not %h", $time, what, got, exp);
		end
	endtask
	task automatic do_reset;
		sys_rst = 1'b1;
		repeat (6) @(posedge mclk);
		#1 sys_rst = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	// Any missing acknowledge is remembered for the caller.
	task automatic put(input logic [7:0] d);
		logic [7:0] r;
		logic a;
		host.xfer(d, 1'b1, r, a);
		nak_seen = nak_seen | a;
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		nak_seen = 1'b0;
		host.start;
		put({dev, 1'b0});
		put(ptr);
		put(d);
		host.stop;
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp,
		input string what);
		logic [7:0] v;
		logic a;
		nak_seen = 1'b0;
		host.start;
		put({dev, 1'b0});
		put(ptr);
		host.start;
		put({dev, 1'b1});
		host.xfer(8'hFF, 1'b1, v, a);
		host.stop;
		chk(v, exp, what);
	endtask
	// The capture needs 14 cycles; 20 leaves room for a stall.
	task automatic tick_sample;
		@(posedge mclk);
		#1 sample_tick = 1'b1;
		@(posedge mclk);
		#1 sample_tick = 1'b0;
		repeat (20) @(posedge mclk);
		#1;
	endtask
	function automatic logic [7:0] exp_byte(input int i);
		return (sample.b[i] == 8'hFF) ? `SQR_MARK_SUBST : sample.b[i];
	endfunction
	task automatic level_is(input logic [7:0] n);
		rd(`SQR_A_LEVEL_HIGH, 8'h00, "level high");
		rd(`SQR_A_LEVEL_LOW, n, "level low");
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_idle;
		rd(`SQR_A_IDENTITY, TB_ID, "identity");
		wr(`SQR_A_IDENTITY, ~TB_ID);
		rd(`SQR_A_IDENTITY, TB_ID, "identity kept");
		level_is(8'h00);
		rd(`SQR_A_DATA_PORT, `SQR_EMPTY_MARK, "empty read");
		rd(`SQR_A_INT_STATUS, 8'h00, "status");
	endtask
	task automatic t_trims;
		logic [7:0] ofs [3];
		ofs = '{`SQR_A_XOFS_HIGH, `SQR_A_YOFS_HIGH, `SQR_A_ZOFS_HIGH};
		for (int i = 0; i < 3; i++) begin
			wr(ofs[i], 8'hA4 + 8'(i));
			wr(ofs[i] + 8'h01, 8'h5B);
			rd(ofs[i], 8'hA4 + 8'(i), "trim high");
			rd(ofs[i] + 8'h01, 8'h5A, "trim low");
		end
		chk({1'b0, accel_x_trim}, {8'hA4, 7'h2D}, "x trim");
		chk({1'b0, accel_y_trim}, {8'hA5, 7'h2D}, "y trim");
		chk({1'b0, accel_z_trim}, {8'hA6, 7'h2D}, "z trim");
	endtask
	task automatic t_address;
		dev = `SQR_I2C_ADDR1;
		wr(`SQR_A_XOFS_HIGH, 8'h11);
		chk(nak_seen, 1'b1, "other address");
		chk(accel_x_trim[14:7], 8'hA4, "ignored write");
		address_select_pin = 1'b1;
		repeat (4) @(posedge mclk);
		#1 rd(`SQR_A_IDENTITY, TB_ID, "select high");
		chk(nak_seen, 1'b0, "select high ack");
		address_select_pin = 1'b0;
		dev = `SQR_I2C_ADDR0;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	// A push between the two level reads must not move the low byte.
	task automatic t_host_queue;
		for (int i = 0; i < 3; i++) wr(`SQR_A_DATA_PORT, 8'h11 * (i + 1));
		rd(`SQR_A_LEVEL_HIGH, 8'h00, "snapshot high");
		wr(`SQR_A_DATA_PORT, 8'h44);
		rd(`SQR_A_LEVEL_LOW, 8'h03, "snapshot low");
		level_is(8'h04);
		for (int i = 0; i < 4; i++)
			rd(`SQR_A_DATA_PORT, 8'h11 * (i + 1), "pop");
		rd(`SQR_A_DATA_PORT, `SQR_EMPTY_MARK, "empty");
		rd(`SQR_A_DATA_PORT, `SQR_EMPTY_MARK, "still empty");
		level_is(8'h00);
	endtask
	task automatic t_capture;
		logic [7:0] en [6];
		int first [6];
		int cnt [6];
		en = '{8'hF8, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08};
		first = '{0, 6, 8, 10, 12, 0};
		cnt = '{14, 2, 2, 2, 2, 6};
		for (int k = 0; k < 6; k++) begin
			wr(`SQR_A_CAP_EN, en[k]);
			tick_sample;
			level_is(8'(cnt[k]));
			for (int j = 0; j < cnt[k]; j++)
				rd(`SQR_A_DATA_PORT, exp_byte(first[k] + j), "order");
		end
	endtask
	task automatic t_overflow;
		wr(`SQR_A_CAP_EN, 8'hF8);
		wr(`SQR_A_CONFIG, 8'h40);
		tick_sample;
		tick_sample;
		chk(queue_overflow_flag, 1'b1, "flag");
		level_is(8'h10);
		rd(`SQR_A_DATA_PORT, exp_byte(0), "oldest kept");
		rd(`SQR_A_INT_STATUS, 8'h10, "status set");
		rd(`SQR_A_INT_STATUS, 8'h00, "status read clear");
		do_reset;
		chk(queue_overflow_flag, 1'b0, "flag reset");
		wr(`SQR_A_CAP_EN, 8'hF8);
		tick_sample;
		tick_sample;
		chk(queue_overflow_flag, 1'b1, "flag drop");
		rd(`SQR_A_DATA_PORT, exp_byte(12), "oldest dropped");
	endtask
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		do_reset;
		for (int i = 0; i < 14; i++) sample.b[i] = 8'h30 + 8'(i);
		sample.b[3] = 8'hFF;
		t_idle;
		t_trims;
		t_address;
		t_host_queue;
		t_capture;
		t_overflow;
		conclude;
	end
	// The tests take about 27400 cycles; over three times that means a hang.
	initial begin
		repeat (90000) @(posedge mclk);
		err_count++;
		conclude;
	end
endmodule
`default_nettype wire
